/* File: hw/qdc_control.sv */
// Purpose: Quad DAC live/stored registers, power-on init and output state
// Assumes: Serial framing decoded elsewhere into cmd/data strobes
// Notes:   Stored copies are flops here; a real part maps them to NVM
`timescale 1ns/1ps
`include "qdc_consts.svh"
module qdc_control
   import qdc_pkg::*;
#(
   parameter int CHANNELS    = 4,
   parameter int INIT_CYCLES = `QDC_INIT_CYCLES
)(
   // Clock and power-on reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // Decoded write command
   input  wire logic                    cmd_valid,
   input  wire logic [7:0]              cmd_byte,
   input  wire logic [7:0]              cmd_data,
   // Read select
   input  wire logic [7:0]              rd_cmd,
   output logic [7:0]                   rd_data,
   // Channel outputs
   output logic [CHANNELS*8-1:0]        level_code,
   output logic [CHANNELS-1:0]          muted,
   output logic [CHANNELS-1:0]          powered_down,
   output logic                         init_busy
);
   typedef struct packed {
      qdc_state_t  state;
      logic [31:0] count;
      logic [7:0]  live_channel_control;
      logic [7:0]  stored_channel_control;
      logic [CHANNELS-1:0][7:0] live_channel_code;
      logic [CHANNELS-1:0][7:0] stored_channel_code;
      logic [7:0]  rd;
      logic        busy;
   } qdc_state_s_t;

   qdc_state_s_t s_r, s_nxt;
   logic [3:0]   sel;
   qdc_action_t  act;
   logic [3:0]   rsel;
   logic         ctl_hit;
   logic         writes_live;
   logic         writes_stored;
   logic [7:0]   live_ctl_nxt;
   logic [7:0]   stored_ctl_nxt;
   logic [CHANNELS-1:0]      code_hit;
   logic [CHANNELS-1:0][7:0] live_code_nxt;
   logic [CHANNELS-1:0][7:0] stored_code_nxt;
   logic [CHANNELS-1:0][7:0] read_code;

   // ---------------------------------------------
   // Command fields
   // ---------------------------------------------
   assign sel  = cmd_byte[`QDC_CMD_REG_LSB +: 4];
   assign act  = qdc_action_t'(cmd_byte[`QDC_CMD_NV_BIT:`QDC_CMD_V_BIT]);
   assign rsel = rd_cmd[`QDC_CMD_REG_LSB +: 4];
   assign ctl_hit = cmd_valid && (sel == `QDC_SEL_CONTROL);
   assign writes_live   = (act == QDC_ACT_LIVE) || (act == QDC_ACT_BOTH);
   assign writes_stored = (act == QDC_ACT_STOR) || (act == QDC_ACT_BOTH);

   // ---------------------------------------------
   // Control register next values
   // ---------------------------------------------
   // Transfer moves stored to live and ignores the data byte
   assign live_ctl_nxt =
      !ctl_hit            ? s_r.live_channel_control   :
      act == QDC_ACT_XFER ? s_r.stored_channel_control :
      writes_live         ? cmd_data                   :
                            s_r.live_channel_control;
   assign stored_ctl_nxt =
      (ctl_hit && writes_stored) ? cmd_data : s_r.stored_channel_control;

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      s_nxt = s_r;
      unique case (s_r.state)
         QDC_ST_LOAD: begin
            s_nxt.live_channel_control =
               s_r.stored_channel_control;
            s_nxt.live_channel_code =
               s_r.stored_channel_code;
            s_nxt.count = 32'h0;
            s_nxt.state = QDC_ST_WAIT;
         end
         QDC_ST_WAIT: begin
            s_nxt.count = s_r.count + 32'h1;
            if (s_r.count >= 32'(INIT_CYCLES - 1)) begin
               s_nxt.state = QDC_ST_RUN;
               s_nxt.busy  = 1'b0;
            end
         end
         QDC_ST_RUN: begin
            // Writes touch only registers; mute state is never implied
            s_nxt.live_channel_control   = live_ctl_nxt;
            s_nxt.stored_channel_control = stored_ctl_nxt;
            s_nxt.live_channel_code      = live_code_nxt;
            s_nxt.stored_channel_code    = stored_code_nxt;
         end
         default: s_nxt.state = QDC_ST_LOAD;
      endcase
      // Read mux; unknown selects read zero
      s_nxt.rd = 8'h00;
      for (int i = 0; i < CHANNELS; i++) begin
         s_nxt.rd = s_nxt.rd | read_code[i];
      end
      if (rsel == `QDC_SEL_CONTROL) begin
         s_nxt.rd = rd_cmd[`QDC_CMD_NV_BIT] ? s_r.stored_channel_control
                                            : s_r.live_channel_control;
      end
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   // Stored copies also take reset here only because flops stand in for
   // NVM; a real part keeps them across power cycles.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r.state                  <= QDC_ST_LOAD;
         s_r.count                  <= 32'h0;
         s_r.live_channel_control   <= `QDC_CONTROL_RESET;
         s_r.stored_channel_control <= `QDC_CONTROL_RESET;
         s_r.live_channel_code      <= '0;
         s_r.stored_channel_code    <= '0;
         s_r.rd                     <= 8'h00;
         s_r.busy                   <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_data   = s_r.rd;
   assign init_busy = s_r.busy;

   // ---------------------------------------------
   // Channel decode and output stages
   // ---------------------------------------------
   for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
      // The all-channel select only carries a live write
      assign code_hit[g] = cmd_valid && !ctl_hit &&
                           (sel == 4'(g) ||
                            (sel == `QDC_SEL_ALL && act == QDC_ACT_LIVE));
      assign live_code_nxt[g] =
         !code_hit[g]        ? s_r.live_channel_code[g]   :
         act == QDC_ACT_XFER ? s_r.stored_channel_code[g] :
         writes_live         ? cmd_data                   :
                               s_r.live_channel_code[g];
      assign stored_code_nxt[g] =
         (code_hit[g] && writes_stored) ? cmd_data
                                        : s_r.stored_channel_code[g];
      assign read_code[g] =
         (rsel != 4'(g))         ? 8'h00                      :
         rd_cmd[`QDC_CMD_NV_BIT] ? s_r.stored_channel_code[g] :
                                   s_r.live_channel_code[g];
      qdc_channel_out u_ch (
         .clk          (clk),
         .reset_n      (reset_n),
         .force_mute   (s_r.busy),
         .mute         (s_r.live_channel_control[`QDC_MUTE_LSB + g]),
         .powerdown    (s_r.live_channel_control[`QDC_PDN_LSB + g]),
         .code         (s_r.live_channel_code[g]),
         .level_code   (level_code[g*8 +: 8]),
         .muted        (muted[g]),
         .powered_down (powered_down[g])
      );
   end
endmodule : qdc_control

/* File: hw/qdc_consts.svh */
// Purpose: Constants for the quad DAC mute/power-down and init control
// Assumes: 20 MHz clock, 8-bit codes, four channels
// Notes:   Overview of operation below
//
// Overview of operation
// - Control bits 7..4 mute channels 3..0; bits 3..0 power them down.
// - Live control copy is plain flops, lost with power.
// - Stored control copy survives power loss; here it is flops that reset_n clears.
// - At power-up the live control is loaded from the stored control.
// - Stored control starts at zero as shipped.
// - Power-on reset loads every live register from its stored copy.
// - Initialization lasts a configurable nominal 500 us.
// - All outputs forced muted during initialization.
// - After initialization outputs follow live control and code.
// - Codes are 8-bit offset binary, sent MSB first.
// - One step is span/256; zero gives low reference.
// - Command low nibble 0100 selects control; bits 5..4 choose action.
// - Mute drives low reference but keeps the live code.
// - Only control writes and transfers change mute; writes during initialization are dropped, not held.
`ifndef QDC_CONSTS_SVH
`define QDC_CONSTS_SVH

`define QDC_CLK_HZ          20000000
`define QDC_INIT_US         500
`define QDC_INIT_CYCLES     ((`QDC_INIT_US * (`QDC_CLK_HZ / 1000000)))
`define QDC_CMD_REG_LSB     0
`define QDC_CMD_NV_BIT      5
`define QDC_CMD_V_BIT       4
`define QDC_SEL_CONTROL     4'h4
`define QDC_SEL_ALL         4'hf
`define QDC_MUTE_LSB        4
`define QDC_PDN_LSB         0
`define QDC_CONTROL_RESET   8'h00
`define QDC_CODE_RESET      8'h00

`endif

/* File: hw/qdc_pkg.sv */
// Purpose: Types for the quad DAC control block
// Assumes: qdc_consts.svh holds the numbers
// Notes:   Action taken from command bits 5..4
package qdc_pkg;
   typedef enum logic [1:0] {
      QDC_ACT_XFER = 2'b00,
      QDC_ACT_LIVE = 2'b01,
      QDC_ACT_STOR = 2'b10,
      QDC_ACT_BOTH = 2'b11
   } qdc_action_t;

   typedef enum logic [1:0] {
      QDC_ST_LOAD = 2'b00,
      QDC_ST_WAIT = 2'b01,
      QDC_ST_RUN  = 2'b11
   } qdc_state_t;
endpackage : qdc_pkg

/* File: hw/qdc_channel_out.sv */
// Purpose: One channel's output stage state
// Assumes: Code and control bits come from the register block
// Notes:   Output level is a code relative to the low reference
`timescale 1ns/1ps
`include "qdc_consts.svh"
module qdc_channel_out
   import qdc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Control
   input  wire logic       force_mute,
   input  wire logic       mute,
   input  wire logic       powerdown,
   input  wire logic [7:0] code,
   // Output state
   output logic [7:0]      level_code,
   output logic            muted,
   output logic            powered_down
);
   typedef struct packed {
      logic [7:0] level;
      logic       mute;
      logic       pdn;
   } qdc_chan_t;

   qdc_chan_t st_r, st_nxt;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.pdn   = powerdown & ~force_mute;
      st_nxt.mute  = (force_mute | mute) & ~st_nxt.pdn;
      // Muted or down sits at the low reference, code kept upstream
      st_nxt.level = (force_mute | mute | powerdown) ?
                     `QDC_CODE_RESET : code;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{level: 8'h00, mute: 1'b1, pdn: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_code   = st_r.level;
   assign muted        = st_r.mute;
   assign powered_down = st_r.pdn;
endmodule : qdc_channel_out

/* File: testbench/qdc_control_properties.sv */
// Purpose: Port assertions for qdc_control
// Assumes: Outputs follow registers one edge later
// Notes:   Bind statement at the foot
`timescale 1ns/1ps
module qdc_control_properties
#(
   parameter int CHANNELS    = 4,
   parameter int INIT_CYCLES = 8
)(
   // Clock, reset and commands
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire logic                  cmd_valid,
   input wire logic [7:0]            cmd_byte,
   input wire logic [7:0]            cmd_data,
   // Channel state
   input wire logic [CHANNELS*8-1:0] level_code,
   input wire logic [CHANNELS-1:0]   muted,
   input wire logic [CHANNELS-1:0]   powered_down,
   input wire logic                  init_busy
);
   int cnt_r;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Saturates just past the init length
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) cnt_r <= 0;
      else if (cnt_r <= INIT_CYCLES) cnt_r <= cnt_r + 1;
   init_busy_a: assert property (
      cnt_r <= INIT_CYCLES |-> init_busy)
      else $error("init ended early");
   init_done_a: assert property (
      cnt_r > INIT_CYCLES |-> !init_busy)
      else $error("init ran long");
   init_mute_a: assert property (
      init_busy |-> muted == '1)
      else $error("mute not forced in init");
   init_quiet_a: assert property (
      init_busy |-> level_code == '0 && powered_down == '0)
      else $error("output active in init");
   pdn_wins_a: assert property (
      (muted & powered_down) == '0)
      else $error("mute and power-down both shown");
   mute_zero_a: assert property (
      muted[0] || powered_down[0] |-> level_code[7:0] == 8'h00)
      else $error("silent channel has level");
   ctl_write_a: assert property (
      cmd_valid && !init_busy && cmd_byte[4] && cmd_byte[3:0] == 4'h4
      |-> ##2 {muted, powered_down} ==
          ($past(cmd_data, 2) & ~($past(cmd_data, 2) << 4)))
      else $error("control write not applied");
   outputs_hold_a: assert property (
      !init_busy && !$past(init_busy, 2) && !$past(cmd_valid, 2)
      |-> $stable({muted, powered_down}))
      else $error("state changed uncommanded");
endmodule : qdc_control_properties
bind qdc_control qdc_control_properties #(
   .CHANNELS    (CHANNELS),
   .INIT_CYCLES (INIT_CYCLES)
) i_props (
   .clk          (clk),
   .reset_n      (reset_n),
   .cmd_valid    (cmd_valid),
   .cmd_byte     (cmd_byte),
   .cmd_data     (cmd_data),
   .level_code   (level_code),
   .muted        (muted),
   .powered_down (powered_down),
   .init_busy    (init_busy)
);

/* File: testbench/qdc_host_model.sv */
// Purpose: Bus controller issuing decoded commands
// Assumes: Drives at the falling edge
// Notes:   Released lines show inverted data
`timescale 1ns/1ps
module qdc_host_model (
   // Clock and read result
   input wire logic  clk,
   input wire logic [7:0] rd_data,
   // Command lines
   output logic      cmd_valid,
   output logic [7:0] cmd_byte,
   output logic [7:0] cmd_data,
   output logic [7:0] rd_cmd
);
   initial begin
      cmd_valid = 1'b0;
      cmd_byte = 8'h00;
      cmd_data = 8'h00;
      rd_cmd = 8'h00;
   end
   task automatic send(input logic [7:0] c, input logic [7:0] d);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_byte = c;
      cmd_data = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_byte = ~c;
      cmd_data = ~d;
   endtask : send
   task automatic fetch(input logic [7:0] c, output logic [7:0] d);
      @(negedge clk);
      rd_cmd = c;
      @(negedge clk);
      d = rd_data;
   endtask : fetch
endmodule : qdc_host_model

/* File: testbench/quad_dac_mute_powerdown_init_tb.sv */
// Purpose: Self-checking bench for qdc_control
// Assumes: Init shortened to 8 cycles
// Notes:   Reset clears stored copies too
`timescale 1ns/1ps
module quad_dac_mute_powerdown_init_tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cmd_valid, init_busy;
   logic [7:0] cmd_byte, cmd_data, rd_cmd, rd_data, rv;
   logic [31:0] level_code;
   logic [3:0] muted, powered_down;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   always #25 clk = ~clk;
   qdc_control #(.INIT_CYCLES(8)) i_dut (
      .clk          (clk),
      .reset_n      (reset_n),
      .cmd_valid    (cmd_valid),
      .cmd_byte     (cmd_byte),
      .cmd_data     (cmd_data),
      .rd_cmd       (rd_cmd),
      .rd_data      (rd_data),
      .level_code   (level_code),
      .muted        (muted),
      .powered_down (powered_down),
      .init_busy    (init_busy)
   );
   qdc_host_model i_host (
      .clk       (clk),
      .rd_data   (rd_data),
      .cmd_valid (cmd_valid),
      .cmd_byte  (cmd_byte),
      .cmd_data  (cmd_data),
      .rd_cmd    (rd_cmd)
   );
   // Wide enough for mute, power-down and all four codes at once
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic cmd(input logic [7:0] c, input logic [7:0] d);
      i_host.send(c, d);
      @(negedge clk);
   endtask : cmd
   // Counts falling edges until init ends
   task automatic wait_init(input int n);
      int k;
      k = 0;
      while (init_busy === 1'b1 && k < 50) begin
         check({muted, level_code}, {4'hf, 32'h0});
         @(negedge clk);
         k++;
      end
      check(k, n);
      @(negedge clk);
      check({muted, powered_down, level_code}, 0);
   endtask : wait_init
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      wait_init(9);
      $display("power-up done");
      for (int i = 0; i < 8; i++) begin
         cmd(8'h14, 8'h01 << i);
         check({muted, powered_down}, 8'h01 << i);
      end
      cmd(8'h14, 8'hff);
      check({muted, powered_down}, 8'h0f);
      $display("control map done");
      cmd(8'h14, 8'h40);
      cmd(8'h1f, 8'h80);
      check(level_code, 32'h8000_8080);
      i_host.fetch(8'h12, rv);
      check(rv, 8'h80);
      i_host.fetch(8'h14, rv);
      check(rv, 8'h40);
      cmd(8'h14, 8'h00);
      check(level_code, 32'h8080_8080);
      cmd(8'h10, 8'hff);
      cmd(8'h13, 8'h00);
      check(level_code, 32'h0080_80ff);
      $display("mute and codes done");
      cmd(8'h24, 8'hf0);
      check(muted, 4'h0);
      i_host.fetch(8'h24, rv);
      check(rv, 8'hf0);
      cmd(8'h04, 8'h00);
      check(muted, 4'hf);
      cmd(8'h34, 8'h0a);
      i_host.fetch(8'h24, rv);
      check({muted, powered_down, rv}, 16'h0a0a);
      cmd(8'h21, 8'h5a);
      cmd(8'h01, 8'h00);
      i_host.fetch(8'h11, rv);
      check(rv, 8'h5a);
      cmd(8'h2f, 8'h33);
      i_host.fetch(8'h21, rv);
      check(rv, 8'h5a);
      $display("stored copies done");
      reset_n = 1'b0;
      @(negedge clk);
      reset_n = 1'b1;
      i_host.send(8'h34, 8'hff);
      i_host.send(8'h1f, 8'h77);
      wait_init(5);
      i_host.fetch(8'h14, rv);
      check(rv, 8'h00);
      $display("reset rerun done");
      tally_and_finish();
   end
endmodule : quad_dac_mute_powerdown_init_tb
